// ==== airs_pkg.sv ====
// package: register addresses, field positions, reset values and mux codes
package airs_pkg;
	localparam logic [7:0] SFR_NEG_SELECT = 8'hBA;
	localparam logic [7:0] SFR_REF_CONTROL = 8'hD1;
	localparam logic [7:0] NEG_SELECT_RESET = 8'h00;
	localparam logic [7:0] REF_CONTROL_RESET = 8'h00;
	localparam logic [7:0] NEG_SELECT_WMASK = 8'h3F;
	localparam logic [7:0] REF_CONTROL_WMASK = 8'h9F;
	localparam int NEG_FIELD_W = 6;
	localparam int BIT_BUF_DRIVE = 0;
	localparam int BIT_BIAS_EN = 1;
	localparam int BIT_TEMP_EN = 2;
	localparam int BIT_SOURCE_SEL = 3;
	localparam int BIT_REG_OVERRIDE = 4;
	localparam int BIT_GAIN_SEL = 7;
	localparam logic [5:0] NEG_CODE_VREF = 6'h1E;
	localparam logic [5:0] NEG_CODE_GND = 6'h1F;
	localparam logic [5:0] NEG_CODE_RSVD_LO = 6'h23;
	typedef enum logic [1:0] {
		AIRS_REF_VREF_PIN,
		AIRS_REF_SUPPLY,
		AIRS_REF_REGULATOR
	} airs_ref_src_t;
	typedef enum logic [1:0] {
		AIRS_NEG_PORT_PIN,
		AIRS_NEG_VREF,
		AIRS_NEG_GND,
		AIRS_NEG_RESERVED
	} airs_neg_kind_t;
endpackage

// ==== airs_neg_decode.sv ====
// negative input decoder: code to pin index per package variant
`timescale 1ns/100ps
module airs_neg_decode
	import airs_pkg::*;
(
	input wire logic [5:0] code,
	input wire logic pkg_48pin,
	output airs_neg_kind_t kind,
	output logic [5:0] pin_index
);
	wire logic rsvd_32;
	wire logic rsvd_48;
	wire logic rsvd;
	// 32-pin parts end at code 0x14, 48-pin parts skip code 0x10
	assign rsvd_32 = (code > 6'h14) && (code != NEG_CODE_VREF) && (code != NEG_CODE_GND);
	assign rsvd_48 = (code == 6'h10) || (code >= NEG_CODE_RSVD_LO);
	assign rsvd = pkg_48pin ? rsvd_48 : rsvd_32;
	assign kind = (code == NEG_CODE_GND) ? AIRS_NEG_GND :
		(code == NEG_CODE_VREF) ? AIRS_NEG_VREF :
		rsvd ? AIRS_NEG_RESERVED : AIRS_NEG_PORT_PIN;
	assign pin_index = (kind == AIRS_NEG_PORT_PIN) ? code : 6'h00;
endmodule

// ==== airs_top.sv ====
// ADC negative input select and reference control registers
`timescale 1ns/100ps
//
// Functional notes
// - negative select register at SFR 0xBA
// - bits 7:6 read zero, writes ignored
// - GND negative selects single-ended mode
// - source bit: 0 VREF pin, 1 supply
// - regulator override wins over source bit
// - peripheral requests enable bias automatically
// - bias enable is bit OR requests
// - gain bit picks buffer 1x or 2x
// - gain bit 0 means 2x, resets 0
// - buffer drive bit drives bandgap to pin
// - reference control resets zero, bits 6:5 zero
module airs_top
	import airs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_we,
	input wire logic sfr_re,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic pkg_48pin,
	input wire logic bias_periph_req,
	output airs_neg_kind_t neg_kind,
	output logic [5:0] neg_pin_index,
	output logic single_ended,
	output airs_ref_src_t ref_source,
	output logic bias_gen_on,
	output logic ref_gain_2x,
	output logic ref_buffer_drive,
	output logic temp_sensor_on
);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] adc_neg_select;
	logic [7:0] reference_control;
	logic [7:0] read_mux;
	logic req_s1;
	logic req_s2;
	logic pkg_s1;
	logic pkg_s2;
	wire logic hit_neg;
	wire logic hit_ref;
	wire logic [7:0] next_adc_neg_select;
	wire logic [7:0] next_reference_control;
	airs_neg_kind_t dec_kind;
	logic [5:0] dec_pin;

	assign hit_neg = (sfr_addr == SFR_NEG_SELECT);
	assign hit_ref = (sfr_addr == SFR_REF_CONTROL);
	// one masking rule for both registers, so unused bits can never store a one
	function automatic logic [7:0] apply_wmask(input logic [7:0] data, input logic [7:0] mask);
		apply_wmask = data & mask;
	endfunction

	assign next_adc_neg_select = apply_wmask(sfr_wdata, NEG_SELECT_WMASK);
	assign next_reference_control = apply_wmask(sfr_wdata, REF_CONTROL_WMASK);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			adc_neg_select <= NEG_SELECT_RESET;
			reference_control <= REF_CONTROL_RESET;
		end
		else
		begin
			if (sfr_we && hit_neg)
				adc_neg_select <= next_adc_neg_select;
			if (sfr_we && hit_ref)
				reference_control <= next_reference_control;
		end
	end

	assign read_mux = hit_neg ? adc_neg_select : hit_ref ? reference_control : 8'h00;
	assign sfr_hit = hit_neg || hit_ref;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (sfr_re)
			sfr_rdata <= read_mux;
	end

	// ----------------------------------------
	// analog control decode
	// ----------------------------------------
	// peripheral request comes from analog domains, so resynchronise it
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end
		else
		begin
			req_s1 <= bias_periph_req;
			req_s2 <= req_s1;
		end
	end

	// the package strap is a pin too; limitation: for two cycles after reset
	// a 48-pin part decodes with the 32-pin table
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pkg_s1 <= 1'b0;
			pkg_s2 <= 1'b0;
		end
		else
		begin
			pkg_s1 <= pkg_48pin;
			pkg_s2 <= pkg_s1;
		end
	end

	airs_neg_decode airs_neg_decode_inst (
		.code(adc_neg_select[NEG_FIELD_W-1:0]),
		.pkg_48pin(pkg_s2),
		.kind(dec_kind),
		.pin_index(dec_pin)
	);

	assign neg_kind = dec_kind;
	assign neg_pin_index = dec_pin;
	assign single_ended = (dec_kind == AIRS_NEG_GND);
	// override takes priority over the source bit
	assign ref_source = reference_control[BIT_REG_OVERRIDE] ? AIRS_REF_REGULATOR :
		reference_control[BIT_SOURCE_SEL] ? AIRS_REF_SUPPLY : AIRS_REF_VREF_PIN;
	assign bias_gen_on = reference_control[BIT_BIAS_EN] || req_s2;
	assign ref_gain_2x = !reference_control[BIT_GAIN_SEL];
	// leaving the drive on wastes pin current; software turns it off when idle
	assign ref_buffer_drive = reference_control[BIT_BUF_DRIVE];
	assign temp_sensor_on = reference_control[BIT_TEMP_EN];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence neg_write_s;
		sfr_we && hit_neg;
	endsequence

	sequence neg_gnd_landed_s;
		neg_write_s ##1 (adc_neg_select[NEG_FIELD_W-1:0] == NEG_CODE_GND);
	endsequence

	sequence bias_idle_s;
		(!bias_periph_req && !reference_control[BIT_BIAS_EN]) [*3];
	endsequence

	chk_neg_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
		neg_write_s |=> adc_neg_select == ($past(sfr_wdata) & 8'h3F))
		else $error("negative select write not stored");
	chk_neg_high_zero: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_re && hit_neg |=> sfr_rdata[7:6] == 2'b00)
		else $error("negative select high bits not zero");
	chk_gnd_single: assert property (@(posedge sys_clk) disable iff (rst)
		single_ended == (adc_neg_select[5:0] == 6'h1F))
		else $error("single-ended mode mismatch");
	chk_vref_kind: assert property (@(posedge sys_clk) disable iff (rst)
		(adc_neg_select[5:0] == 6'h1E) |-> neg_kind == AIRS_NEG_VREF)
		else $error("vref code misdecoded");
	chk_ref_supply: assert property (@(posedge sys_clk) disable iff (rst)
		!reference_control[4] && reference_control[3] |-> ref_source == AIRS_REF_SUPPLY)
		else $error("supply reference not selected");
	chk_override_wins: assert property (@(posedge sys_clk) disable iff (rst)
		reference_control[4] |-> ref_source == AIRS_REF_REGULATOR)
		else $error("regulator override ignored");
	chk_bias_auto: assert property (@(posedge sys_clk) disable iff (rst)
		bias_periph_req [*3] |-> bias_gen_on)
		else $error("bias not enabled by request");
	chk_bias_or: assert property (@(posedge sys_clk) disable iff (rst)
		bias_gen_on == (reference_control[1] || req_s2))
		else $error("bias enable is not the OR");
	chk_gain_map: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_we && hit_ref && !sfr_wdata[7] |=> ref_gain_2x)
		else $error("gain bit zero must give 2x");
	chk_ref_unused: assert property (@(posedge sys_clk) disable iff (rst)
		reference_control[6:5] == 2'b00)
		else $error("reference control unused bits set");
	chk_drive_follows: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_we && hit_ref |=> ref_buffer_drive == $past(sfr_wdata[0]))
		else $error("buffer drive not following write");
	chk_gain_one_x: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_we && hit_ref && sfr_wdata[BIT_GAIN_SEL] |=> !ref_gain_2x)
		else $error("gain bit one must give 1x");
	chk_source_vref: assert property (@(posedge sys_clk) disable iff (rst)
		!reference_control[BIT_REG_OVERRIDE] && !reference_control[BIT_SOURCE_SEL]
		|-> ref_source == AIRS_REF_VREF_PIN)
		else $error("reference pin not selected");
	chk_rsvd_top: assert property (@(posedge sys_clk) disable iff (rst)
		(adc_neg_select[NEG_FIELD_W-1:0] >= NEG_CODE_RSVD_LO)
		|-> neg_kind == AIRS_NEG_RESERVED)
		else $error("high reserved code misdecoded");
	chk_pin_index: assert property (@(posedge sys_clk) disable iff (rst)
		neg_kind != AIRS_NEG_PORT_PIN |-> neg_pin_index == 6'h00)
		else $error("pin index set for non-pin input");
	chk_neg_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
		adc_neg_select[7:6] == 2'b00)
		else $error("negative select upper bits stored");
	chk_miss_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_re && !sfr_hit |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_miss_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_we && !sfr_hit |=> $stable(adc_neg_select) && $stable(reference_control))
		else $error("unmapped write changed a register");
	chk_read_old_value: assert property (@(posedge sys_clk) disable iff (rst)
		sfr_re && sfr_we && hit_neg |=> sfr_rdata == $past(adc_neg_select))
		else $error("read during write not old value");
	chk_gnd_follows_write: assert property (@(posedge sys_clk) disable iff (rst)
		neg_gnd_landed_s |-> single_ended && neg_kind == AIRS_NEG_GND)
		else $error("ground selection not applied after write");
	chk_bias_idle_off: assert property (@(posedge sys_clk) disable iff (rst)
		bias_idle_s |-> !bias_gen_on)
		else $error("bias on with no request");
endmodule

// ==== airs_top_tb.sv ====
// self-checking testbench for the adc input and reference select block
`timescale 1ns/100ps
module airs_top_tb
	import airs_pkg::*;
;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rd; logic [7:0] outs;
		logic [7:0] aux;} airs_row_t;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_we = 1'b0;
	logic sfr_re = 1'b0;
	logic pkg_48pin = 1'b0;
	logic bias_periph_req = 1'b0;
	logic [7:0] sfr_rdata;
	logic sfr_hit;
	airs_neg_kind_t neg_kind;
	logic [5:0] neg_pin_index;
	logic single_ended;
	airs_ref_src_t ref_source;
	logic bias_gen_on;
	logic ref_gain_2x;
	logic ref_buffer_drive;
	logic temp_sensor_on;
	logic [7:0] data;
	int miscompares = 0;
	int total_checks = 0;
	wire [7:0] outs = {neg_kind, single_ended, ref_source, bias_gen_on, ref_gain_2x, ref_buffer_drive};
	wire [7:0] aux = {sfr_hit, temp_sensor_on, neg_pin_index};
	// outs packs kind, single_ended, source, bias, gain_2x, drive; aux packs hit, temp, pin
	airs_row_t rows [9] = '{'{8'hBA, 8'hFF, 8'h3F, 8'hC2, 8'h80}, '{8'hBA, 8'h1F, 8'h1F, 8'hA2, 8'h80},
		'{8'hD1, 8'hFF, 8'h9F, 8'hB5, 8'hC0}, '{8'hD1, 8'h08, 8'h08, 8'hAA, 8'h80},
		'{8'hBA, 8'h1E, 8'h1E, 8'h4A, 8'h80}, '{8'hD1, 8'h60, 8'h00, 8'h42, 8'h80},
		'{8'h55, 8'hAA, 8'h00, 8'h42, 8'h00}, '{8'hBA, 8'h05, 8'h05, 8'h02, 8'h85},
		'{8'hBA, 8'h15, 8'h15, 8'hC2, 8'h80}};
	airs_top airs_top_inst (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.pkg_48pin(pkg_48pin), .bias_periph_req(bias_periph_req), .neg_kind(neg_kind),
		.neg_pin_index(neg_pin_index), .single_ended(single_ended), .ref_source(ref_source),
		.bias_gen_on(bias_gen_on), .ref_gain_2x(ref_gain_2x), .ref_buffer_drive(ref_buffer_drive),
		.temp_sensor_on(temp_sensor_on));
	// ----------------------------------------
	// clock, bus tasks and checks
	// ----------------------------------------
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// strobes are held across one rising edge, so outputs are settled at the next falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_we = 1'b1;
		@(negedge sys_clk);
		sfr_we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_re = 1'b1;
		@(negedge sys_clk);
		sfr_re = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		check("reset outputs", 8'h02, outs);
		rd(SFR_NEG_SELECT, data);
		check("reset select", 8'h00, data);
		rd(SFR_REF_CONTROL, data);
		check("reset control", 8'h00, data);
		$display("test reset done");
		for (int i = 0; i < 9; i++)
		begin
			wr(rows[i].addr, rows[i].wdata);
			check("outputs", rows[i].outs, outs);
			check("hit temp pin", rows[i].aux, aux);
			rd(rows[i].addr, data);
			check("rdata", rows[i].rd, data);
		end
		$display("test table done");
		pkg_48pin = 1'b1;
		wr(SFR_NEG_SELECT, 8'h10);
		check("kind and pin", 8'hC0, {neg_kind, neg_pin_index});
		wr(SFR_NEG_SELECT, 8'h22);
		check("kind and pin", 8'h22, {neg_kind, neg_pin_index});
		$display("test package variant done");
		@(negedge sys_clk);
		sfr_addr = SFR_NEG_SELECT;
		sfr_wdata = 8'h07;
		sfr_we = 1'b1;
		sfr_re = 1'b1;
		@(negedge sys_clk);
		sfr_we = 1'b0;
		sfr_re = 1'b0;
		check("read during write", 8'h22, sfr_rdata);
		check("kind and pin", 8'h07, {neg_kind, neg_pin_index});
		$display("test read during write done");
		@(negedge sys_clk);
		bias_periph_req = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("bias on", 8'h01, {7'h00, bias_gen_on});
		bias_periph_req = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("bias off", 8'h00, {7'h00, bias_gen_on});
		$display("test bias request done");
		wr(SFR_REF_CONTROL, 8'h02);
		check("bias by bit", 8'h01, {7'h00, bias_gen_on});
		wr(SFR_REF_CONTROL, 8'h01);
		check("bias and drive", 8'h01, {6'h00, bias_gen_on, ref_buffer_drive});
		wr(SFR_REF_CONTROL, 8'h00);
		check("drive off", 8'h00, {7'h00, ref_buffer_drive});
		$display("test bias bit and drive done");
		wr(SFR_NEG_SELECT, 8'h1F);
		wr(SFR_REF_CONTROL, 8'h97);
		rd(SFR_REF_CONTROL, data);
		check("control before reset", 8'h97, data);
		check("temp on", 8'h01, {7'h00, temp_sensor_on});
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		check("mid reset outputs", 8'h02, outs);
		check("mid reset rdata", 8'h00, sfr_rdata);
		check("mid reset temp", 8'h00, {7'h00, temp_sensor_on});
		rd(SFR_NEG_SELECT, data);
		check("mid reset select", 8'h00, data);
		$display("test mid-run reset done");
		tally_and_finish();
	end
	// the whole run needs well under 200 cycles
	initial
	begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
endmodule
